//--- rtl/cpb_device.sv
// Purpose: coprocessor end of the memory mapped bus port
// Assumes: host glue keeps its own obligations; datapath is outside
// Notes:   all outputs come from the registered state record
//
// Overview of operation
// - check even parity, report after write acknowledge
// - parity error high outside that cycle
// - parity error affects nothing else
// - glue merges device ready into host ready
// - transfer done input ends current transfer
// - glue routes interrupt to interrupt controller
// - drive presence low; board pull-up otherwise
// - glue acknowledges transfers to absent coprocessor
// - select low while coprocessor transfer pending
// - glue holds cache enable off in the strobe cycle and one cycle behind select, so it is on in the first select cycle
// - slow read adds one wait state
// - slow read sampled only with address strobe
// - option A: page cache disable drives slow read
// - option B: slow read high, fast decode
// - instruction from address 15..2 and enables 2..0
// - select from address 31..25 and memory cycle
// - respond to whole C0000000..C1FFFFFF range
// - write executes, read drives data bus
// - nothing else occupies the decoded space
// - everything timed from the shared clock
// - backoff abandons tracked bus cycle
`timescale 1ns/1ps
module cpb_device (
	input  wire logic                          clk,
	input  wire logic                          rst,
	cpb_if.device                              bus,
	output logic                               execValid,
	output logic [cpb_pkg::OP_W-1:0]           execOpcode,
	output logic [cpb_pkg::OPBE_W-1:0]         execByteEnN,
	output logic [cpb_pkg::DATA_W-1:0]         execData,
	output logic                               execParityErr,
	input  wire logic [cpb_pkg::DATA_W-1:0]    readData,
	input  wire logic                          exceptionIn
);
	typedef struct packed {
		cpb_pkg::cpb_dev_st_t              st;
		logic                              wr;
		logic [1:0]                        waits;
		logic [cpb_pkg::OP_W-1:0]          op;
		logic [cpb_pkg::OPBE_W-1:0]        be;
		logic                              selN;
		logic                              rdyN;
		logic                              parN;
		logic                              interrupt_request;
		logic                              presN;
		logic [cpb_pkg::DATA_W-1:0]        dOut;
		logic [cpb_pkg::LANES-1:0]         pOut;
		logic                              dOeN;
		logic                              exec;
		logic [cpb_pkg::DATA_W-1:0]        xData;
		logic                              xPerr;
	} cpb_dev_t;

	localparam cpb_dev_t DEV_RST = '{
		st:    cpb_pkg::DEV_IDLE,
		wr:    1'b0,
		waits: 2'h0,
		op:    '0,
		be:    '1,
		selN:  1'b1,
		rdyN:  1'b1,
		parN:  1'b1,
		interrupt_request:  1'b0,
		presN: 1'b0,
		dOut:  cpb_pkg::DATA_IDLE,
		pOut:  cpb_pkg::PAR_IDLE,
		dOeN:  1'b1,
		exec:  1'b0,
		xData: '0,
		xPerr: 1'b0
	};

	cpb_dev_t                          q;
	cpb_dev_t                          d;
	logic [cpb_pkg::LANES-1:0]         laneOdd;
	logic [cpb_pkg::LANES-1:0]         readPar;
	logic                              parityBad;
	logic                              hit;

	// per lane even parity check of write data and parity generation for reads
	genvar gi;
	generate
		for (gi = 0; gi < cpb_pkg::LANES; gi++) begin : g_lane
			assign laneOdd[gi] = ^{bus.dataBus[gi*cpb_pkg::LANE_W +: cpb_pkg::LANE_W],
				bus.parBus[gi]};
			assign readPar[gi] = ^readData[gi*cpb_pkg::LANE_W +: cpb_pkg::LANE_W];
		end
	endgenerate
	assign parityBad = |laneOdd;

	// only the top seven address bits and the memory cycle select the port
	assign hit = bus.memNotIo &&
		(bus.address[cpb_pkg::SEL_MSB:cpb_pkg::SEL_LSB] == cpb_pkg::SEL_BASE);

	// next state of the whole port
	always_comb begin
		d       = q;
		d.parN  = 1'b1;
		d.exec  = 1'b0;
		d.interrupt_request  = exceptionIn;
		d.presN = 1'b0;
		unique case (q.st)
			cpb_pkg::DEV_IDLE: begin
				if (!bus.addressStrobeN && hit) begin
					d.op   = bus.address[cpb_pkg::OP_MSB:cpb_pkg::OP_LSB];
					d.be   = bus.byteEnableN[cpb_pkg::OPBE_W-1:0];
					d.wr   = bus.writeNotRead;
					d.selN = 1'b0;
					if (!bus.writeNotRead && !bus.slowReadN) begin
						d.st    = cpb_pkg::DEV_WAIT;
						d.waits = cpb_pkg::SLOW_WAITS;
					end else begin
						d.st   = cpb_pkg::DEV_ACK;
						d.rdyN = 1'b0;
						if (!bus.writeNotRead) begin
							d.dOut = readData;
							d.pOut = readPar;
							d.dOeN = 1'b0;
						end
					end
				end
			end
			cpb_pkg::DEV_WAIT: begin
				d.waits = q.waits - 2'h1;
				if (q.waits == 2'h1) begin
					d.st   = cpb_pkg::DEV_ACK;
					d.rdyN = 1'b0;
					d.dOut = readData;
					d.pOut = readPar;
					d.dOeN = 1'b0;
				end
			end
			cpb_pkg::DEV_ACK: begin
				if (!bus.transferDoneInN) begin
					d.st   = cpb_pkg::DEV_IDLE;
					d.selN = 1'b1;
					d.rdyN = 1'b1;
					d.dOeN = 1'b1;
					d.dOut = cpb_pkg::DATA_IDLE;
					d.pOut = cpb_pkg::PAR_IDLE;
					if (q.wr) begin
						d.parN  = !parityBad;
						d.exec  = 1'b1;
						d.xData = bus.dataBus;
						d.xPerr = parityBad;
					end
				end
			end
			default: begin
				d = DEV_RST;
			end
		endcase
		// an abandoned cycle drops everything at once
		if (!bus.backoffN && (q.st != cpb_pkg::DEV_IDLE)) begin
			d.st   = cpb_pkg::DEV_IDLE;
			d.selN = 1'b1;
			d.rdyN = 1'b1;
			d.dOeN = 1'b1;
			d.exec = 1'b0;
			d.parN = 1'b1;
			d.dOut = cpb_pkg::DATA_IDLE;
			d.pOut = cpb_pkg::PAR_IDLE;
		end
	end

	// state register on the shared clock
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= DEV_RST;
		end else begin
			q <= d;
		end
	end

	// bus side outputs
	assign bus.devData          = q.dOut;
	assign bus.devPar           = q.pOut;
	assign bus.devDataOeN       = q.dOeN;
	assign bus.deviceReadyOutN  = q.rdyN;
	assign bus.coprocSelectN    = q.selN;
	assign bus.parityErrorN     = q.parN;
	assign bus.interruptRequest = q.interrupt_request;
	assign bus.presentN         = q.presN;

	// datapath side outputs
	assign execValid     = q.exec;
	assign execOpcode    = q.op;
	assign execByteEnN   = q.be;
	assign execData      = q.xData;
	assign execParityErr = q.xPerr; // informational only
endmodule : cpb_device

//--- rtl/cpb_pkg.sv
// Purpose: shared constants and types of the coprocessor bus port
// Assumes: one clock shared by host glue and coprocessor port
// Notes:   address field positions are those of the host bus
package cpb_pkg;
	localparam int ADDR_W   = 32;
	localparam int DATA_W   = 32;
	localparam int LANES    = 4;
	localparam int LANE_W   = 8;
	localparam int BE_W     = 4;
	localparam int OPBE_W   = 3;
	// select decode uses address bits 31..25 only
	localparam int SEL_MSB  = 31;
	localparam int SEL_LSB  = 25;
	localparam int SEL_W    = SEL_MSB - SEL_LSB + 1;
	localparam logic [SEL_W-1:0] SEL_BASE = 7'h60;
	// instruction field is address bits 15..2
	localparam int OP_MSB   = 15;
	localparam int OP_LSB   = 2;
	localparam int OP_W     = OP_MSB - OP_LSB + 1;
	// wait states added to a read when slow read is asserted
	localparam logic [1:0] SLOW_WAITS = 2'h1;
	localparam logic [DATA_W-1:0] DATA_IDLE = 32'hFFFFFFFF;
	localparam logic [LANES-1:0]  PAR_IDLE  = 4'hF;

	typedef enum logic [2:0] {
		DEV_IDLE = 3'h1,
		DEV_WAIT = 3'h2,
		DEV_ACK  = 3'h4
	} cpb_dev_st_t;

	typedef enum logic [2:0] {
		HST_IDLE = 3'h1,
		HST_ADDR = 3'h2,
		HST_PEND = 3'h4
	} cpb_hst_st_t;
endpackage : cpb_pkg

//--- rtl/cpb_if.sv
// Purpose: bus wiring between host glue and coprocessor port
// Assumes: both ends run on the same clock
// Notes:   shared data lines resolve from the two low-active enables
`timescale 1ns/1ps
interface cpb_if;
	logic [cpb_pkg::ADDR_W-1:0] address;
	logic [cpb_pkg::BE_W-1:0]   byteEnableN;
	logic                       addressStrobeN;
	logic                       memNotIo;
	logic                       writeNotRead;
	logic                       backoffN;
	logic                       transferDoneInN;
	logic                       slowReadN;
	logic                       cacheEnableN;
	logic [cpb_pkg::DATA_W-1:0] hostData;
	logic [cpb_pkg::LANES-1:0]  hostPar;
	logic                       hostDataOeN;
	logic [cpb_pkg::DATA_W-1:0] devData;
	logic [cpb_pkg::LANES-1:0]  devPar;
	logic                       devDataOeN;
	logic                       deviceReadyOutN;
	logic                       coprocSelectN;
	logic                       parityErrorN;
	logic                       interruptRequest;
	logic                       presentN;
	logic [cpb_pkg::DATA_W-1:0] dataBus;
	logic [cpb_pkg::LANES-1:0]  parBus;

	// resolved lines; undriven lines float high
	assign dataBus = !devDataOeN ? devData :
		(!hostDataOeN ? hostData : cpb_pkg::DATA_IDLE);
	assign parBus  = !devDataOeN ? devPar :
		(!hostDataOeN ? hostPar : cpb_pkg::PAR_IDLE);

	modport device (
		input  address, byteEnableN, addressStrobeN, memNotIo, writeNotRead,
		input  backoffN, transferDoneInN, slowReadN, dataBus, parBus,
		output devData, devPar, devDataOeN, deviceReadyOutN, coprocSelectN,
		output parityErrorN, interruptRequest, presentN
	);
	modport host (
		output address, byteEnableN, addressStrobeN, memNotIo, writeNotRead,
		output backoffN, transferDoneInN, slowReadN, cacheEnableN,
		output hostData, hostPar, hostDataOeN,
		input  dataBus, parBus, deviceReadyOutN, coprocSelectN,
		input  parityErrorN, interruptRequest, presentN
	);
endinterface : cpb_if

//--- rtl/cpb_host.sv
// Purpose: host bus and board glue end of the coprocessor port
// Assumes: one request at a time from the user side
// Notes:   ready to the device is registered, so acks come a cycle late
`timescale 1ns/1ps
module cpb_host #(
	parameter bit OPTION_A = 1'b1
) (
	input  wire logic                          clk,
	input  wire logic                          rst,
	cpb_if.host                                bus,
	input  wire logic                          reqValid,
	input  wire logic                          reqWrite,
	input  wire logic [cpb_pkg::ADDR_W-1:0]    reqAddr,
	input  wire logic [cpb_pkg::BE_W-1:0]      reqByteEnN,
	input  wire logic [cpb_pkg::DATA_W-1:0]    reqData,
	input  wire logic                          pageCacheDisable,
	input  wire logic                          backoffReq,
	output logic                               reqBusy,
	output logic                               respValid,
	output logic [cpb_pkg::DATA_W-1:0]         respData,
	output logic                               parityFault,
	output logic                               irq,
	output logic                               coprocFitted
);
	typedef struct packed {
		cpb_pkg::cpb_hst_st_t              st;
		logic [cpb_pkg::ADDR_W-1:0]        addr;
		logic [cpb_pkg::BE_W-1:0]          be;
		logic                              adsN;
		logic                              mem;
		logic                              wr;
		logic                              boffN;
		logic                              doneN;
		logic                              tcrN;
		logic                              kenN;
		logic [cpb_pkg::DATA_W-1:0]        dOut;
		logic [cpb_pkg::LANES-1:0]         pOut;
		logic                              oeN;
		logic                              busy;
		logic                              rv;
		logic [cpb_pkg::DATA_W-1:0]        rData;
		logic                              pf;
		logic                              irq;
		logic                              fit;
	} cpb_hst_t;

	localparam cpb_hst_t HST_RST = '{
		st: cpb_pkg::HST_IDLE, addr: '0, be: '1, adsN: 1'b1, mem: 1'b0,
		wr: 1'b0, boffN: 1'b1, doneN: 1'b1, tcrN: 1'b1, kenN: 1'b1,
		dOut: cpb_pkg::DATA_IDLE, pOut: cpb_pkg::PAR_IDLE, oeN: 1'b1,
		busy: 1'b0, rv: 1'b0, rData: '0, pf: 1'b0, irq: 1'b0, fit: 1'b0
	};

	cpb_hst_t                          q;
	cpb_hst_t                          d;
	logic [cpb_pkg::LANES-1:0]         wrPar;
	logic                              reqHit;
	logic                              curHit;

	// even parity per lane for write data
	genvar gi;
	generate
		for (gi = 0; gi < cpb_pkg::LANES; gi++) begin : g_lane
			assign wrPar[gi] = ^reqData[gi*cpb_pkg::LANE_W +: cpb_pkg::LANE_W];
		end
	endgenerate

	// the whole decoded space belongs to the coprocessor
	assign reqHit = (reqAddr[cpb_pkg::SEL_MSB:cpb_pkg::SEL_LSB] == cpb_pkg::SEL_BASE);
	assign curHit = (q.addr[cpb_pkg::SEL_MSB:cpb_pkg::SEL_LSB] == cpb_pkg::SEL_BASE);

	// next state of glue and bus master
	always_comb begin
		d       = q;
		d.rv    = 1'b0;
		d.boffN = !backoffReq;
		d.tcrN  = OPTION_A ? pageCacheDisable : 1'b1;
		d.kenN  = !bus.coprocSelectN ? 1'b1 : 1'b0;
		d.pf    = !bus.parityErrorN;
		d.irq   = bus.interruptRequest;
		d.fit   = !bus.presentN;
		unique case (q.st)
			cpb_pkg::HST_IDLE: begin
				if (reqValid) begin
					d.st   = cpb_pkg::HST_ADDR;
					d.addr = reqAddr;
					d.be   = reqByteEnN;
					d.adsN = 1'b0;
					d.mem  = 1'b1;
					d.wr   = reqWrite;
					d.busy = 1'b1;
					d.kenN = reqHit ? 1'b1 : d.kenN;
					if (reqWrite) begin
						d.dOut = reqData;
						d.pOut = wrPar;
						d.oeN  = 1'b0;
					end
				end
			end
			cpb_pkg::HST_ADDR: begin
				d.adsN = 1'b1;
				d.st   = cpb_pkg::HST_PEND;
			end
			cpb_pkg::HST_PEND: begin
				if (!q.doneN) begin
					d.st    = cpb_pkg::HST_IDLE;
					d.doneN = 1'b1;
					d.busy  = 1'b0;
					d.oeN   = 1'b1;
					d.dOut  = cpb_pkg::DATA_IDLE;
					d.pOut  = cpb_pkg::PAR_IDLE;
					d.rv    = 1'b1;
					d.rData = bus.dataBus;
				end else if (!bus.deviceReadyOutN || bus.presentN || !curHit) begin
					d.doneN = 1'b0;
				end
			end
			default: begin
				d = HST_RST;
			end
		endcase
		// backoff abandons the cycle without an answer
		if (!q.boffN && (q.st != cpb_pkg::HST_IDLE)) begin
			d.st    = cpb_pkg::HST_IDLE;
			d.adsN  = 1'b1;
			d.doneN = 1'b1;
			d.busy  = 1'b0;
			d.oeN   = 1'b1;
			d.rv    = 1'b0;
		end
	end

	// state register on the shared clock
	always_ff @(posedge clk) begin
		if (rst) begin
			q <= HST_RST;
		end else begin
			q <= d;
		end
	end

	assign bus.address         = q.addr;
	assign bus.byteEnableN     = q.be;
	assign bus.addressStrobeN  = q.adsN;
	assign bus.memNotIo        = q.mem;
	assign bus.writeNotRead    = q.wr;
	assign bus.backoffN        = q.boffN;
	assign bus.transferDoneInN = q.doneN;
	assign bus.slowReadN       = q.tcrN;
	assign bus.cacheEnableN    = q.kenN;
	assign bus.hostData        = q.dOut;
	assign bus.hostPar         = q.pOut;
	assign bus.hostDataOeN     = q.oeN;
	assign reqBusy             = q.busy;
	assign respValid           = q.rv;
	assign respData            = q.rData;
	assign parityFault         = q.pf;
	assign irq                 = q.irq;
	assign coprocFitted        = q.fit;
endmodule : cpb_host

//--- test/cpb_checker.sv
// Purpose: wire checks between host glue and coprocessor port
// Assumes: one clock, synchronous active-high reset
// Notes:   select base 7'h60 is address C0000000 shifted down by 25
`timescale 1ns/1ps
module cpb_checker (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic [31:0] address,
	input wire logic        addressStrobeN,
	input wire logic        memNotIo,
	input wire logic        writeNotRead,
	input wire logic        backoffN,
	input wire logic        transferDoneInN,
	input wire logic        slowReadN,
	input wire logic [31:0] dataBus,
	input wire logic [3:0]  parBus,
	input wire logic        devDataOeN,
	input wire logic        deviceReadyOutN,
	input wire logic        coprocSelectN,
	input wire logic        parityErrorN,
	input wire logic        cacheEnableN
);
	logic hit;
	logic take;
	logic parBad;
	logic ackW;

	// coprocessor strobe, strobe to an idle port, odd lane, write acknowledge
	assign hit    = !addressStrobeN && memNotIo && address[31:25] == 7'h60;
	assign take   = hit && coprocSelectN && backoffN;
	assign parBad = ^{dataBus[7:0], parBus[0]} | ^{dataBus[15:8], parBus[1]}
		| ^{dataBus[23:16], parBus[2]} | ^{dataBus[31:24], parBus[3]};
	assign ackW   = !transferDoneInN && !coprocSelectN && devDataOeN && backoffN;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_par_chk;
		ackW |=> parityErrorN == !$past(parBad);
	endproperty
	a_par_chk: assert property (p_par_chk) else $error("parity report wrong");
	property p_par_idle;
		!parityErrorN |-> $past(ackW);
	endproperty
	a_par_idle: assert property (p_par_idle) else $error("stray parity low");
	property p_sel_hit;
		take |=> !coprocSelectN;
	endproperty
	a_sel_hit: assert property (p_sel_hit) else $error("hit not selected");
	property p_sel_miss;
		!addressStrobeN && coprocSelectN && !hit |=> coprocSelectN;
	endproperty
	a_sel_miss: assert property (p_sel_miss) else $error("miss selected");
	property p_rdy_fast;
		take && (writeNotRead || slowReadN) |=> !deviceReadyOutN;
	endproperty
	a_rdy_fast: assert property (p_rdy_fast) else $error("ready late");
	property p_rdy_slow;
		take && !writeNotRead && !slowReadN |=> deviceReadyOutN ##1 !deviceReadyOutN;
	endproperty
	a_rdy_slow: assert property (p_rdy_slow) else $error("slow read wrong");
	property p_sel_hold;
		!coprocSelectN && transferDoneInN && backoffN |=> !coprocSelectN;
	endproperty
	a_sel_hold: assert property (p_sel_hold) else $error("select dropped");
	property p_sel_end;
		!coprocSelectN && !transferDoneInN |=> coprocSelectN && deviceReadyOutN;
	endproperty
	a_sel_end: assert property (p_sel_end) else $error("select held");
	property p_drive;
		!devDataOeN |-> !deviceReadyOutN && !coprocSelectN;
	endproperty
	a_drive: assert property (p_drive) else $error("data driven idle");
	property p_ken_sel;
		!coprocSelectN |=> cacheEnableN;
	endproperty
	a_ken_sel: assert property (p_ken_sel) else $error("cache enabled in transfer");
endmodule : cpb_checker

//--- test/memory_mapped_coprocessor_bus_port_bench.sv
// Purpose: self-checking bench for host glue and coprocessor port
// Assumes: 250 MHz clock, reset held three cycles
// Notes:   a second port faces bench-driven lines for faulty cycles
`timescale 1ns/1ps
module memory_mapped_coprocessor_bus_port_bench;
	typedef struct {logic w; logic [31:0] a; logic [3:0] be; logic page_cache_disable; int lat;} cpb_row_t;
	logic        clk;
	logic        rst = 1'b1;
	logic        reqValid = 1'b0;
	logic        reqWrite = 1'b0;
	logic        pageCacheDisable = 1'b1;
	logic        backoffReq = 1'b0;
	logic        exceptionIn = 1'b0;
	logic [31:0] reqAddr = 32'h0;
	logic [31:0] reqData = 32'h0;
	logic [31:0] readData = 32'h0;
	logic [3:0]  reqByteEnN = 4'hF;
	logic [31:0] respData;
	logic [31:0] execData;
	logic [13:0] execOpcode;
	logic [2:0]  execByteEnN;
	logic        reqBusy, respValid, parityFault, irq, coprocFitted, execValid, execValid2;
	int          errTotal = 0;
	int          checkCount = 0;
	cpb_row_t    rows [6] = '{
		'{1'b1, 32'hC0000000, 4'h0, 1'b1, 3},
		'{1'b1, 32'hC1FFFFFC, 4'h8, 1'b0, 3},
		'{1'b0, 32'hC000FFFC, 4'h5, 1'b1, 3},
		'{1'b0, 32'hC1000010, 4'h2, 1'b0, 4},
		'{1'b0, 32'hBFFFFFFC, 4'h0, 1'b1, 3},
		'{1'b1, 32'hC2000000, 4'h0, 1'b1, 3}};

	cpb_if bus ();
	cpb_if bus2 ();

	// joined ends, a second port on bench lines, and the wire checker
	cpb_host u_cpb_host (.clk, .rst, .bus(bus), .reqValid, .reqWrite, .reqAddr, .reqByteEnN,
		.reqData, .pageCacheDisable, .backoffReq, .reqBusy, .respValid, .respData,
		.parityFault, .irq, .coprocFitted);
	cpb_device u_cpb_device (.clk, .rst, .bus(bus), .execValid, .execOpcode, .execByteEnN,
		.execData, .execParityErr(), .readData, .exceptionIn);
	cpb_device u_cpb_device_b (.clk, .rst, .bus(bus2), .execValid(execValid2), .execOpcode(),
		.execByteEnN(), .execData(), .execParityErr(), .readData, .exceptionIn);
	cpb_checker u_cpb_checker (.clk, .rst, .address(bus.address),
		.addressStrobeN(bus.addressStrobeN), .memNotIo(bus.memNotIo),
		.writeNotRead(bus.writeNotRead), .backoffN(bus.backoffN),
		.transferDoneInN(bus.transferDoneInN), .slowReadN(bus.slowReadN),
		.dataBus(bus.dataBus), .parBus(bus.parBus), .devDataOeN(bus.devDataOeN),
		.deviceReadyOutN(bus.deviceReadyOutN), .coprocSelectN(bus.coprocSelectN),
		.parityErrorN(bus.parityErrorN), .cacheEnableN(bus.cacheEnableN));

	// free-running 4 ns clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errTotal++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check

	// print counts and verdict, then stop
	task automatic giveVerdict;
		$display("Checks %0d, mismatches %0d", checkCount, errTotal);
		if (errTotal == 0 && checkCount > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : giveVerdict

	// one request through the host user side, sampled on falling edges
	task automatic runReq(input cpb_row_t r);
		int   n;
		logic sawExec;
		logic hit;
		hit = r.a[31:25] == 7'h60;
		@(posedge clk);
		reqValid <= 1'b1;
		reqWrite <= r.w;
		reqAddr <= r.a;
		reqByteEnN <= r.be;
		reqData <= ~r.a;
		readData <= {r.a[15:0], r.a[31:16]};
		pageCacheDisable <= r.page_cache_disable;
		@(posedge clk);
		reqValid <= 1'b0;
		n = -1;
		sawExec = 1'b0;
		do begin
			@(negedge clk);
			n++;
			sawExec |= execValid;
		end while (respValid !== 1'b1 && n < 12);
		check(n, r.lat);
		check(sawExec, r.w && hit);
		// parity fault follows the report by one more cycle
		@(negedge clk);
		check(parityFault, 1'b0);
		check(coprocFitted, 1'b1);
		if (hit) begin
			check(execOpcode, r.a[15:2]);
			check(execByteEnN, r.be[2:0]);
			if (r.w)
				check(execData, ~r.a);
			else
				check(respData, {r.a[15:0], r.a[31:16]});
		end
	endtask : runReq

	// one cycle on the second port; backoff_n abandons it, io makes it an IO cycle
	task automatic cyc2(input logic w, io, backoff_n, slow, input logic [3:0] par, input int lat);
		int n;
		@(posedge clk);
		bus2.memNotIo <= !io;
		bus2.writeNotRead <= w;
		bus2.hostDataOeN <= !w;
		bus2.hostPar <= par;
		bus2.addressStrobeN <= 1'b0;
		bus2.slowReadN <= !slow;
		@(posedge clk);
		bus2.addressStrobeN <= 1'b1;
		bus2.slowReadN <= slow;
		n = 0;
		do begin
			@(negedge clk);
			n++;
		end while (bus2.deviceReadyOutN !== 1'b0 && n < 6);
		check(n, lat);
		if (!w && !io)
			check(bus2.dataBus, readData);
		if (!w && !io)
			check(^{bus2.dataBus, bus2.parBus}, 1'b0);
		@(posedge clk);
		bus2.backoffN <= !backoff_n;
		bus2.transferDoneInN <= backoff_n;
		@(posedge clk);
		bus2.backoffN <= 1'b1;
		bus2.transferDoneInN <= 1'b1;
		bus2.hostDataOeN <= 1'b1;
		@(negedge clk);
		check(bus2.coprocSelectN, 1'b1);
		check(execValid2, w && !io && !backoff_n);
		check(bus2.parityErrorN, !(w && !io && !backoff_n && !(^par)));
		@(negedge clk);
		check(bus2.parityErrorN, 1'b1);
	endtask : cyc2

	// cut a hang: the whole run needs well under 1000 cycles
	initial begin
		#20000;
		errTotal++;
		giveVerdict();
	end

	// reset, request table, faulty cycles, then reset in mid-transfer
	initial begin
		bus2.address = 32'hC0000104;
		bus2.byteEnableN = 4'h0;
		bus2.addressStrobeN = 1'b1;
		bus2.memNotIo = 1'b1;
		bus2.writeNotRead = 1'b0;
		bus2.backoffN = 1'b1;
		bus2.transferDoneInN = 1'b1;
		bus2.slowReadN = 1'b1;
		bus2.hostData = 32'h1;
		bus2.hostPar = 4'h1;
		bus2.hostDataOeN = 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		foreach (rows[i])
			runReq(rows[i]);
		cyc2(1'b1, 1'b0, 1'b0, 1'b0, 4'h0, 1);
		cyc2(1'b1, 1'b0, 1'b0, 1'b0, 4'h1, 1);
		cyc2(1'b0, 1'b0, 1'b0, 1'b1, 4'h0, 2);
		cyc2(1'b0, 1'b0, 1'b0, 1'b0, 4'h0, 1);
		cyc2(1'b1, 1'b0, 1'b1, 1'b0, 4'h0, 1);
		cyc2(1'b1, 1'b1, 1'b0, 1'b0, 4'h1, 6);
		@(posedge clk);
		reqValid <= 1'b1;
		reqWrite <= 1'b1;
		reqAddr <= 32'hC0000000;
		exceptionIn <= 1'b1;
		@(posedge clk);
		reqValid <= 1'b0;
		@(posedge clk);
		@(negedge clk);
		check(irq, 1'b1);
		@(posedge clk);
		rst <= 1'b1;
		exceptionIn <= 1'b0;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		check({bus.coprocSelectN, bus.deviceReadyOutN, bus.parityErrorN, bus.devDataOeN,
			bus.presentN, reqBusy, respValid, execValid}, 8'hF0);
		runReq(rows[0]);
		giveVerdict();
	end
endmodule : memory_mapped_coprocessor_bus_port_bench
